// >>> hw/tuner_cfg_params.svh
// Function
// - Radio data ready pulses pin two low
// - Seek/tune done pulses pin two low
// - Pin two mode 01 idles high
// - Modes 00 float, 10 low, 11 high
// - Pin three mode 01 shows stereo
// - Bit 12 enables radio data processing
// - Emphasis bit picks 75 or 50 us
// - Gain control off bit disables AGC
// - Blend field selects RSSI window
// - Stereo flag above window low bound
// - Seek threshold rejects weaker channels
// - Band field selects frequency range
// - Step field selects channel spacing
// - Volume zero mutes, else log steps
// - Extended range lowers volume 30 dB
// - Both registers reset to zero
// - Done flag set, host clears it
`ifndef TUNER_CFG_PARAMS_SVH
`define TUNER_CFG_PARAMS_SVH
`define CFG_ONE_IDX 8'h04
`define CFG_TWO_IDX 8'h05
`define IRQ_STAT_IDX 8'h08
`define IRQ_MASK_IDX 8'h09
`define LIVE_IDX 8'h0A
`define CFG_RESET 16'h0000
`define CFG_ONE_WMASK 16'hDCFF
`define BIT_RDS_IEN 15
`define BIT_STC_IEN 14
`define BIT_RDS_EN 12
`define BIT_EMPH 11
`define BIT_AGC_OFF 10
`define PULSE_NS 5000000
`define CLK_NS 25
`define PULSE_CYCLES (`PULSE_NS / `CLK_NS)
`endif

// >>> hw/tuner_cfg_pkg.sv
package tuner_cfg_pkg;
    typedef enum logic [1:0] {
        PIN_FLOAT = 2'b00,
        PIN_SPECIAL = 2'b01,
        PIN_LOW = 2'b10,
        PIN_HIGH = 2'b11
    } pin_mode_t;
    typedef enum logic [0:0] {
        PULSE_IDLE = 1'b0,
        PULSE_ACTIVE = 1'b1
    } pulse_state_t;
endpackage : tuner_cfg_pkg

// >>> hw/tuner_system_config_regs.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
`include "tuner_cfg_params.svh"
module tuner_system_config_regs
    import tuner_cfg_pkg::*;
#(
    parameter int PULSE_LEN = `PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rds_ready_i,
    input wire logic seek_tune_done_i,
    input wire logic [7:0] rssi_i,
    output logic pin_one_o,
    output logic pin_one_oe_o,
    output logic pin_two_o,
    output logic pin_two_oe_o,
    output logic pin_three_o,
    output logic pin_three_oe_o,
    output logic rds_en_o,
    output logic emphasis_curve_o,
    output logic gain_ctrl_off_o,
    output logic two_channel_flag_o,
    output logic [7:0] seek_level_min_o,
    output logic [1:0] freq_range_sel_o,
    output logic [1:0] channel_step_o,
    output logic [3:0] volume_o,
    input wire logic vol_range_ext_i,
    output logic [5:0] atten_db_o,
    output logic mute_o,
    output logic irq_o
);
    localparam int PCW = $clog2(PULSE_LEN + 1);

    logic [15:0] cfg_one_r;
    logic [15:0] cfg_two_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic rds_s1_r, rds_s2_r, rds_d_r;
    logic stc_s1_r, stc_s2_r, stc_d_r;
    logic [7:0] rssi_s1_r, rssi_s2_r;
    pulse_state_t pstate_r;
    logic [PCW-1:0] pcnt_r;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0] idx = wb_adr_i[9:2];
    wire wr = req & wb_we_i;
    wire lo_en = wb_sel_i[0];
    wire hi_en = wb_sel_i[1];
    wire wr_one = wr & (idx == `CFG_ONE_IDX);
    wire wr_two = wr & (idx == `CFG_TWO_IDX);
    wire wr_stat = wr & (idx == `IRQ_STAT_IDX) & lo_en;
    wire wr_mask = wr & (idx == `IRQ_MASK_IDX) & lo_en;
    wire [15:0] sel16 = {{8{hi_en}}, {8{lo_en}}};
    // Reserved bits kept zero even if the host slips
    wire [15:0] one_mask = sel16 & `CFG_ONE_WMASK;

    wire [1:0] pin_one_mode = cfg_one_r[1:0];
    wire [1:0] pin_two_mode = cfg_one_r[3:2];
    wire [1:0] pin_three_mode = cfg_one_r[5:4];
    wire [1:0] blend_level_adj = cfg_one_r[7:6];

    // Rising edges of synchronised event levels
    wire rds_ready = rds_s2_r & ~rds_d_r;
    wire seek_tune_done = stc_s2_r & ~stc_d_r;
    wire [1:0] ev = {seek_tune_done, rds_ready};

    wire trig_rds = rds_ready & cfg_one_r[`BIT_RDS_IEN];
    wire trig_stc = seek_tune_done & cfg_one_r[`BIT_STC_IEN];
    wire pin_two_irq = pin_two_mode == PIN_SPECIAL;
    wire trig = (trig_rds | trig_stc) & pin_two_irq;

    // Blend window low bounds in dBuV: 31, 37, 19, 25
    logic [7:0] blend_low;
    always_comb begin
        case (blend_level_adj)
            2'b00: blend_low = 8'h1F;
            2'b01: blend_low = 8'h25;
            2'b10: blend_low = 8'h13;
            default: blend_low = 8'h19;
        endcase
    end
    wire stereo = rssi_s2_r > blend_low;

    // Pin drive: value and enable per mode
    function automatic logic [1:0] drive(input logic [1:0] m,
                                         input logic special);
        case (m)
            PIN_FLOAT: drive = 2'b00;
            PIN_SPECIAL: drive = {1'b1, special};
            PIN_LOW: drive = 2'b10;
            default: drive = 2'b11;
        endcase
    endfunction : drive

    // Pin one code 01 reserved: left floating
    wire [1:0] d_one = (pin_one_mode == PIN_SPECIAL) ? 2'b00
                       : drive(pin_one_mode, 1'b0);
    wire pulse_low = pstate_r == PULSE_ACTIVE;
    wire [1:0] d_two = drive(pin_two_mode, ~pulse_low);
    wire [1:0] d_three = drive(pin_three_mode, stereo);

    // Volume attenuation in dB from full scale, 2 dB per step
    wire [3:0] vol = cfg_two_r[3:0];
    wire [5:0] vol_att = 6'((4'hF - vol) << 1);
    wire [5:0] att = vol_range_ext_i ? 6'(vol_att + 6'h1E)
                     : vol_att;

    wire [31:0] rd_mux =
        (idx == `CFG_ONE_IDX) ? {16'h0000, cfg_one_r} :
        (idx == `CFG_TWO_IDX) ? {16'h0000, cfg_two_r} :
        (idx == `IRQ_STAT_IDX) ? {30'h0, irq_stat_r} :
        (idx == `IRQ_MASK_IDX) ? {30'h0, irq_mask_r} :
        (idx == `LIVE_IDX) ? {22'h0, pulse_low, stereo, rssi_s2_r} :
        32'h00000000;

    wire [1:0] stat_nxt = (irq_stat_r & ~(wr_stat ? wb_dat_i[1:0] : 2'b00))
                          | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_one_r <= `CFG_RESET;
            cfg_two_r <= `CFG_RESET;
            irq_stat_r <= 2'b00;
            irq_mask_r <= 2'b00;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_mux : 32'h00000000;
            if (wr_one)
                cfg_one_r <= (cfg_one_r & ~one_mask)
                             | (wb_dat_i[15:0] & one_mask);
            if (wr_two)
                cfg_two_r <= (cfg_two_r & ~sel16) | (wb_dat_i[15:0] & sel16);
            irq_stat_r <= stat_nxt;
            if (wr_mask)
                irq_mask_r <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rds_s1_r <= 1'b0;
            rds_s2_r <= 1'b0;
            rds_d_r <= 1'b0;
            stc_s1_r <= 1'b0;
            stc_s2_r <= 1'b0;
            stc_d_r <= 1'b0;
            rssi_s1_r <= 8'h00;
            rssi_s2_r <= 8'h00;
        end else begin
            rds_s1_r <= rds_ready_i;
            rds_s2_r <= rds_s1_r;
            rds_d_r <= rds_s2_r;
            stc_s1_r <= seek_tune_done_i;
            stc_s2_r <= stc_s1_r;
            stc_d_r <= stc_s2_r;
            rssi_s1_r <= rssi_i;
            rssi_s2_r <= rssi_s1_r;
        end
    end

    // Low pulse timer; new events during a pulse are absorbed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pstate_r <= PULSE_IDLE;
            pcnt_r <= '0;
        end else begin
            case (pstate_r)
                PULSE_IDLE: begin
                    if (trig) begin
                        pstate_r <= PULSE_ACTIVE;
                        pcnt_r <= PCW'(PULSE_LEN - 1);
                    end
                end
                PULSE_ACTIVE: begin
                    if (pcnt_r == '0)
                        pstate_r <= PULSE_IDLE;
                    else
                        pcnt_r <= pcnt_r - 1'b1;
                end
                default: pstate_r <= PULSE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {pin_one_oe_o, pin_one_o} <= 2'b00;
            {pin_two_oe_o, pin_two_o} <= 2'b00;
            {pin_three_oe_o, pin_three_o} <= 2'b00;
            rds_en_o <= 1'b0;
            emphasis_curve_o <= 1'b0;
            gain_ctrl_off_o <= 1'b0;
            two_channel_flag_o <= 1'b0;
            seek_level_min_o <= 8'h00;
            freq_range_sel_o <= 2'b00;
            channel_step_o <= 2'b00;
            volume_o <= 4'h0;
            atten_db_o <= 6'h00;
            mute_o <= 1'b1;
            irq_o <= 1'b0;
        end else begin
            {pin_one_oe_o, pin_one_o} <= d_one;
            {pin_two_oe_o, pin_two_o} <= d_two;
            {pin_three_oe_o, pin_three_o} <= d_three;
            rds_en_o <= cfg_one_r[`BIT_RDS_EN];
            emphasis_curve_o <= cfg_one_r[`BIT_EMPH];
            gain_ctrl_off_o <= cfg_one_r[`BIT_AGC_OFF];
            two_channel_flag_o <= stereo;
            seek_level_min_o <= cfg_two_r[15:8];
            freq_range_sel_o <= cfg_two_r[7:6];
            channel_step_o <= cfg_two_r[5:4];
            volume_o <= vol;
            atten_db_o <= att;
            mute_o <= vol == 4'h0;
            irq_o <= |(stat_nxt & irq_mask_r);
        end
    end
endmodule : tuner_system_config_regs

// >>> test/tb_tuner_system_config_regs.sv
`timescale 1ns/10ps
module tb_tuner_system_config_regs;
    localparam int PULSE = 20;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic vol_range_ext_i = 0, rds_ready_i, seek_tune_done_i, wb_ack_o;
    logic [9:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic [7:0] rssi_i, seek_level_min_o;
    logic [1:0] freq_range_sel_o, channel_step_o;
    logic [3:0] volume_o;
    logic [5:0] atten_db_o;
    logic pin_one_o, pin_one_oe_o, pin_two_o, pin_two_oe_o, pin_three_o;
    logic pin_three_oe_o, rds_en_o, emphasis_curve_o, gain_ctrl_off_o;
    logic two_channel_flag_o, mute_o, irq_o;
    logic [15:0] q;
    int fail_count = 0, compares = 0, n;
    logic [7:0] low_bound [4] = '{8'h1F, 8'h25, 8'h13, 8'h19};
    tuner_system_config_regs #(.PULSE_LEN(PULSE)) tuner_system_config_regs_i (.*);
    tuner_core_model tuner_core_model_i (.clk_i(clk_i),
        .rds_ready_o(rds_ready_i), .seek_tune_done_o(seek_tune_done_i),
        .rssi_o(rssi_i));
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [15:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Spare edges let registered outputs settle
        repeat (3) @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        wb(1'b0, idx, 16'h0000);
        chk(q, exp);
    endtask : rd
    task automatic complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({pin_one_oe_o, pin_two_oe_o, pin_three_oe_o, mute_o, rds_en_o,
            emphasis_curve_o, gain_ctrl_off_o}, 16'h0008);
        rd(8'h04, 16'h0000);
        rd(8'h05, 16'h0000);
        rd(8'h03, 16'h0000);
        wb(1'b1, 8'h04, 16'hDCFF);
        rd(8'h04, 16'hDCFF);
        chk({rds_en_o, emphasis_curve_o, gain_ctrl_off_o}, 16'h0007);
        for (int m = 0; m < 4; m += (m == 0) ? 2 : 1) begin
            wb(1'b1, 8'h04, {10'h000, m[1:0], m[1:0], m[1:0]});
            chk({pin_one_oe_o, pin_one_o, pin_two_oe_o, pin_two_o,
                pin_three_oe_o, pin_three_o}, {3{m != 0, m[0]}});
        end
        for (int b = 0; b < 4; b++) begin
            wb(1'b1, 8'h04, {8'h00, b[1:0], 6'h15});
            for (int s = 1; s >= 0; s--) begin
                tuner_core_model_i.set_rssi(low_bound[b] + 8'(s));
                repeat (6) @(posedge clk_i);
                chk({two_channel_flag_o, pin_three_oe_o, pin_three_o,
                    pin_one_oe_o, pin_two_oe_o, pin_two_o},
                    {s[0], 1'b1, s[0], 3'b011});
            end
        end
        rd(8'h0A, 16'h0019);
        wb(1'b1, 8'h05, 16'h7F95);
        chk({seek_level_min_o, freq_range_sel_o, channel_step_o, volume_o},
            16'h7F95);
        for (int v = 0; v < 2; v++) begin
            vol_range_ext_i <= v[0];
            wb(1'b1, 8'h05, 16'h0001);
            chk({mute_o, atten_db_o}, v ? 16'h003A : 16'h001C);
        end
        wb(1'b1, 8'h05, 16'h0000);
        chk(mute_o, 16'h0001);
        for (int e = 0; e < 2; e++) begin
            wb(1'b1, 8'h04, 16'hC004);
            tuner_core_model_i.flag(e, 1'b1);
            @(negedge pin_two_o);
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
                if (n == 5) tuner_core_model_i.flag(1 - e, 1'b1);
            end while (pin_two_o === 1'b0);
            chk(16'(n - 1), 16'(PULSE));
            repeat (10) @(posedge clk_i);
            chk(pin_two_o, 16'h0001);
            rd(8'h08, 16'h0003);
            chk(irq_o, 16'(e));
            wb(1'b1, 8'h09, 16'h0003);
            chk(irq_o, 16'h0001);
            tuner_core_model_i.flag(0, 1'b0);
            tuner_core_model_i.flag(1, 1'b0);
            wb(1'b1, 8'h08, 16'h0003);
            chk(irq_o, 16'h0000);
        end
        complete_run();
    end
endmodule : tb_tuner_system_config_regs
bind tuner_system_config_regs tuner_cfg_assertions tuner_cfg_assertions_i (.*);

// >>> test/tuner_cfg_assertions.sv
`timescale 1ns/10ps
module tuner_cfg_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic pin_two_o,
    input wire logic pin_two_oe_o,
    input wire logic vol_range_ext_i,
    input wire logic [7:0] seek_level_min_o,
    input wire logic [3:0] volume_o,
    input wire logic [5:0] atten_db_o,
    input wire logic mute_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    mute_code_a: assert property (mute_o == (volume_o == 4'h0))
        else $error("mute does not follow volume");
    atten_step_a: assert property (!mute_o |-> int'(atten_db_o) ==
        30 - 2 * int'(volume_o) + ($past(vol_range_ext_i) ? 30 : 0))
        else $error("attenuation wrong");
    cfg_hold_a: assert property ($changed({seek_level_min_o, volume_o}) |->
        $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("field changed without a write");
    pulse_min_a: assert property ($fell(pin_two_o) && pin_two_oe_o &&
        $past(pin_two_oe_o) |-> !pin_two_o [*8])
        else $error("low pulse cut short");
endmodule : tuner_cfg_assertions

// >>> test/tuner_core_model.sv
`timescale 1ns/10ps
module tuner_core_model (
    input wire logic clk_i,
    output logic rds_ready_o,
    output logic seek_tune_done_o,
    output logic [7:0] rssi_o
);
    logic [1:0] flag_r = 2'b00;
    assign rds_ready_o = flag_r[0];
    assign seek_tune_done_o = flag_r[1];
    initial rssi_o = 8'h00;
    // Flags stay up until the host side clears them
    task automatic flag(input int e, input logic v);
        flag_r[e] <= v;
    endtask : flag
    task automatic set_rssi(input logic [7:0] v);
        rssi_o <= v;
    endtask : set_rssi
endmodule : tuner_core_model
